// [tpcpc_pkg.sv]
// Purpose: shared constants and types for the timer channel pin control block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: offsets are byte addresses
package tpcpc_pkg;
    localparam int TPCPC_CNT_W = 16;
    localparam int TPCPC_NCH = 2;
    localparam logic [7:0] TPCPC_OFF_CTRL = 8'h00;
    localparam logic [7:0] TPCPC_OFF_MOD = 8'h04;
    localparam logic [7:0] TPCPC_OFF_CNT = 8'h08;
    localparam logic [7:0] TPCPC_OFF_CH0_CTL = 8'h10;
    localparam logic [7:0] TPCPC_OFF_CH0_VAL = 8'h14;
    localparam logic [7:0] TPCPC_CH_STRIDE = 8'h08;
    localparam int TPCPC_CTRL_CLKS_LSB = 0;
    localparam int TPCPC_CTRL_CPWM_BIT = 2;
    localparam int TPCPC_CTRL_FIX_DIV_LSB = 8;
    localparam int TPCPC_CHC_ELS_LSB = 0;
    localparam int TPCPC_CHC_MS_LSB = 2;
    localparam int TPCPC_CHC_FLAG_BIT = 7;
    localparam logic [1:0] TPCPC_CLKS_RESET = 2'h0;
    localparam logic [15:0] TPCPC_MOD_RESET = 16'h0000;
    localparam logic [7:0] TPCPC_FIX_DIV_RESET = 8'h03;
    localparam logic [15:0] TPCPC_COUNT_ZERO = 16'h0000;
    localparam int TPCPC_SYNC_STAGES = 2;
    typedef enum logic [1:0] {
        TPCPC_CLK_OFF,
        TPCPC_CLK_BUS,
        TPCPC_CLK_FIXED,
        TPCPC_CLK_EXT
    } tpcpc_clks_t;
endpackage

// [tpcpc_edge_sync.sv]
// Purpose: two-flop synchroniser with rise and fall pulses
// Assumes: input asynchronous to clk_in
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module tpcpc_edge_sync (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // raw level
    input wire logic async_in,
    // synchronised level and edge pulses
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);
    import tpcpc_pkg::*;
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } tpcpc_sync_t;
    tpcpc_sync_t st_reg, st_next;
    always_comb begin
        st_next = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign level_out = st_reg.s2;
    assign rise_out = st_reg.s2 & ~st_reg.s3;
    assign fall_out = ~st_reg.s2 & st_reg.s3;
endmodule
`default_nettype wire

// [tpcpc_top.sv]
// Purpose: timer channel pin control with counter, capture, compare and pwm
// Assumes: apb slave, 20 MHz bus clock, pins synchronous except ext clock and captures
// Notes: channel pins use in, out and output enable; gpio owns pin when channel_pin_owned_out is low
// Summary of operation
// - clock select: off, bus, fixed, external
// - external clock synchronised on bus clock
// - external clock pin keeps software compare
// - pin released when edge or clock zero
// - center mode drives every owned channel pin
// - mode bits pick capture, compare, pwm
// - capture mode makes pin timer input
// - edge select picks capture polarity
// - capture edges pass bus-clock synchroniser
// - compare mode drives pin as output
// - compare match toggles, clears or sets
// - toggle keeps previous level until match
// - pwm bit selects edge pwm, polarity
// - high at zero, low on match
// - inverted: low at zero, high match
// - center mode polarity per channel
// - center: clear up-match, set down-match
// - inverted center: set up, clear down
// - capture copies counter, sets flag
// - edge pwm period modulo plus one
// - center counts up then down
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tpcpc_top #(
    parameter int NUM_CH = tpcpc_pkg::TPCPC_NCH
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // external clock source
    input wire logic ext_clock_in,
    // channel pins
    input wire logic [NUM_CH-1:0] channel_pin_in,
    output logic [NUM_CH-1:0] channel_pin_out,
    output logic [NUM_CH-1:0] channel_pin_oe_out,
    output logic [NUM_CH-1:0] channel_pin_owned_out
);
    import tpcpc_pkg::*;

    typedef struct packed {
        logic [1:0] clks;
        logic cpwm;
        logic [7:0] fix_div;
        logic [7:0] fix_cnt;
        logic [15:0] modv;
        logic [15:0] cnt;
        logic down;
        logic [NUM_CH-1:0][1:0] els;
        logic [NUM_CH-1:0][1:0] ms;
        logic [NUM_CH-1:0] flag;
        logic [NUM_CH-1:0][15:0] val;
        logic [NUM_CH-1:0] pin;
        logic [31:0] rdata;
    } tpcpc_state_t;

    tpcpc_state_t st_reg, st_next;
    logic ext_level, ext_rise, ext_fall;
    logic [NUM_CH-1:0] cap_lvl, cap_rise, cap_fall;
    logic tick;
    logic wr, rd;
    logic [NUM_CH-1:0] owned;

    tpcpc_edge_sync u_ext_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in(ext_clock_in),
        .level_out(ext_level),
        .rise_out(ext_rise),
        .fall_out()
    );

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_sync
            tpcpc_edge_sync u_cap_sync (
                .clk_in(clk_in),
                .rst_n_in(rst_n_in),
                .async_in(channel_pin_in[g]),
                .level_out(cap_lvl[g]),
                .rise_out(cap_rise[g]),
                .fall_out(cap_fall[g])
            );
        end
    endgenerate

    always_comb begin
        unique case (tpcpc_clks_t'(st_reg.clks))
            TPCPC_CLK_OFF: tick = 1'b0;
            TPCPC_CLK_BUS: tick = 1'b1;
            TPCPC_CLK_FIXED: tick = (st_reg.fix_cnt == st_reg.fix_div);
            TPCPC_CLK_EXT: tick = ext_rise;
        endcase
    end

    assign wr = psel_in & penable_in & pwrite_in;
    assign rd = psel_in & ~penable_in & ~pwrite_in;

    // pin ownership per channel
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (st_reg.els[i] == 2'h0 || st_reg.clks == 2'h0) begin
                owned[i] = 1'b0;
            end else begin
                owned[i] = 1'b1;
            end
        end
    end

    always_comb begin
        logic [15:0] nc;
        logic top, bot;
        logic [NUM_CH-1:0] hit;
        nc = st_reg.cnt;
        top = 1'b0;
        bot = 1'b0;
        hit = '0;
        st_next = st_reg;
        st_next.rdata = 32'h0000_0000;
        // fixed clock divider
        if (st_reg.clks == 2'(TPCPC_CLK_FIXED)) begin
            st_next.fix_cnt = tick ? 8'h00 : 8'(st_reg.fix_cnt + 8'h01);
        end else begin
            st_next.fix_cnt = 8'h00;
        end
        if (tick) begin
            top = (st_reg.modv == 16'h0000) ? (st_reg.cnt == 16'hFFFF)
                                            : (st_reg.cnt == st_reg.modv);
            if (st_reg.cpwm) begin
                if (!st_reg.down) begin
                    if (top) begin
                        st_next.down = 1'b1;
                        nc = 16'(st_reg.cnt - 16'h0001);
                    end else begin
                        nc = 16'(st_reg.cnt + 16'h0001);
                    end
                end else begin
                    if (st_reg.cnt == TPCPC_COUNT_ZERO + 16'h0001) begin
                        st_next.down = 1'b0;
                    end
                    nc = 16'(st_reg.cnt - 16'h0001);
                end
            end else begin
                nc = top ? TPCPC_COUNT_ZERO : 16'(st_reg.cnt + 16'h0001);
                st_next.down = 1'b0;
            end
            st_next.cnt = nc;
        end
        bot = tick & ~st_reg.cpwm & (nc == TPCPC_COUNT_ZERO);
        // collect this cycle's flag events apart from the held flags
        st_next.flag = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            logic match;
            match = tick & (nc == st_reg.val[i]);
            if (st_reg.cpwm) begin
                if (owned[i] && match) begin
                    st_next.pin[i] = st_reg.els[i][0] ? ~st_next.down : st_next.down;
                    st_next.flag[i] = 1'b1;
                end
            end else if (!st_reg.ms[i][1] && !st_reg.ms[i][0]) begin
                if (owned[i] && ((st_reg.els[i][0] && cap_rise[i]) ||
                                 (st_reg.els[i][1] && cap_fall[i]))) begin
                    st_next.val[i] = st_reg.cnt;
                    st_next.flag[i] = 1'b1;
                end
                st_next.pin[i] = cap_lvl[i];
            end else if (!st_reg.ms[i][1]) begin
                if (match) begin
                    st_next.flag[i] = 1'b1;
                end
                if (match && owned[i]) begin
                    unique case (st_reg.els[i])
                        2'h1: st_next.pin[i] = ~st_reg.pin[i];
                        2'h2: st_next.pin[i] = 1'b0;
                        2'h3: st_next.pin[i] = 1'b1;
                        default: st_next.pin[i] = st_reg.pin[i];
                    endcase
                end
            end else begin
                if (owned[i]) begin
                    if (match) begin
                        st_next.pin[i] = st_reg.els[i][0];
                        st_next.flag[i] = 1'b1;
                    end else if (bot) begin
                        st_next.pin[i] = ~st_reg.els[i][0];
                    end
                end
            end
        end
        hit = st_next.flag;
        st_next.flag = st_next.flag | st_reg.flag;
        // apb writes
        if (wr) begin
            if (paddr_in == TPCPC_OFF_CTRL) begin
                st_next.clks = pwdata_in[TPCPC_CTRL_CLKS_LSB +: 2];
                st_next.cpwm = pwdata_in[TPCPC_CTRL_CPWM_BIT];
                st_next.fix_div = pwdata_in[TPCPC_CTRL_FIX_DIV_LSB +: 8];
            end else if (paddr_in == TPCPC_OFF_MOD) begin
                st_next.modv = pwdata_in[15:0];
            end else if (paddr_in == TPCPC_OFF_CNT) begin
                st_next.cnt = TPCPC_COUNT_ZERO;
                st_next.down = 1'b0;
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (paddr_in == 8'(TPCPC_OFF_CH0_CTL + 8'(i) * TPCPC_CH_STRIDE)) begin
                    st_next.els[i] = pwdata_in[TPCPC_CHC_ELS_LSB +: 2];
                    st_next.ms[i] = pwdata_in[TPCPC_CHC_MS_LSB +: 2];
                    // write one clears; a same-cycle event wins
                    if (pwdata_in[TPCPC_CHC_FLAG_BIT] && !hit[i]) begin
                        st_next.flag[i] = 1'b0;
                    end
                end
                if (paddr_in == 8'(TPCPC_OFF_CH0_VAL + 8'(i) * TPCPC_CH_STRIDE)) begin
                    st_next.val[i] = pwdata_in[15:0];
                end
            end
        end
        // apb read data captured in setup
        if (rd) begin
            if (paddr_in == TPCPC_OFF_CTRL) begin
                st_next.rdata[TPCPC_CTRL_CLKS_LSB +: 2] = st_reg.clks;
                st_next.rdata[TPCPC_CTRL_CPWM_BIT] = st_reg.cpwm;
                st_next.rdata[TPCPC_CTRL_FIX_DIV_LSB +: 8] = st_reg.fix_div;
                st_next.rdata[16] = st_reg.down;
                st_next.rdata[17] = ext_level;
            end else if (paddr_in == TPCPC_OFF_MOD) begin
                st_next.rdata[15:0] = st_reg.modv;
            end else if (paddr_in == TPCPC_OFF_CNT) begin
                st_next.rdata[15:0] = st_reg.cnt;
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (paddr_in == 8'(TPCPC_OFF_CH0_CTL + 8'(i) * TPCPC_CH_STRIDE)) begin
                    st_next.rdata[TPCPC_CHC_ELS_LSB +: 2] = st_reg.els[i];
                    st_next.rdata[TPCPC_CHC_MS_LSB +: 2] = st_reg.ms[i];
                    st_next.rdata[TPCPC_CHC_FLAG_BIT] = st_reg.flag[i];
                    st_next.rdata[8] = st_reg.pin[i];
                end
                if (paddr_in == 8'(TPCPC_OFF_CH0_VAL + 8'(i) * TPCPC_CH_STRIDE)) begin
                    st_next.rdata[15:0] = st_reg.val[i];
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
            st_reg.clks <= TPCPC_CLKS_RESET;
            st_reg.modv <= TPCPC_MOD_RESET;
            st_reg.fix_div <= TPCPC_FIX_DIV_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // pin drive
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            channel_pin_owned_out[i] = owned[i];
            channel_pin_oe_out[i] = owned[i] & (st_reg.cpwm | (st_reg.ms[i] != 2'h0));
            channel_pin_out[i] = st_reg.pin[i];
        end
    end

    assign prdata_out = st_reg.rdata;
    assign pready_out = 1'b1;
    assign pslverr_out = 1'b0;
endmodule
`default_nettype wire

// [tpcpc_top_monitor.sv]
// Purpose: port checks for the timer channel pin control block
// Assumes: mode shadows follow apb writes
// Notes: mode checks wait three quiet cycles after any write
`timescale 1ns/1ps
`default_nettype none
module tpcpc_top_monitor #(
    parameter int NUM_CH = 2
) (
    // clock, reset and apb
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic pready_out,
    // channel pins
    input wire logic [NUM_CH-1:0] channel_pin_in,
    input wire logic [NUM_CH-1:0] channel_pin_out,
    input wire logic [NUM_CH-1:0] channel_pin_oe_out,
    input wire logic [NUM_CH-1:0] channel_pin_owned_out
);
    import tpcpc_pkg::*;
    typedef struct packed {
        logic [1:0] clks;
        logic center;
        logic [3:0] ch0;
        logic [1:0] els1;
        logic [1:0] quiet;
    } tpcpc_mon_t;
    tpcpc_mon_t mon_reg;
    tpcpc_mon_t mon_next;
    logic q3, run, drv0, cap0;
    always_comb begin
        mon_next = mon_reg;
        mon_next.quiet = mon_reg.quiet + {1'b0, mon_reg.quiet != 2'h3};
        if (psel_in && penable_in && pwrite_in && pready_out) begin
            mon_next.quiet = 2'h0;
            if (paddr_in == TPCPC_OFF_CTRL) mon_next.clks = pwdata_in[1:0];
            if (paddr_in == TPCPC_OFF_CTRL) mon_next.center = pwdata_in[2];
            if (paddr_in == TPCPC_OFF_CH0_CTL) mon_next.ch0 = pwdata_in[3:0];
            if (paddr_in == TPCPC_OFF_CH0_CTL + TPCPC_CH_STRIDE) mon_next.els1 = pwdata_in[1:0];
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) mon_reg <= '0;
        else mon_reg <= mon_next;
    end
    assign q3 = mon_reg.quiet == 2'h3;
    assign run = q3 && mon_reg.clks != 2'h0;
    assign drv0 = run && !mon_reg.center && mon_reg.ch0[1:0] != 2'h0;
    assign cap0 = drv0 && mon_reg.ch0[3:2] == 2'h0;
    default clocking mon_cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    chk_release_gpio: assert property (
        q3 && (mon_reg.ch0[1:0] == 2'h0 || mon_reg.clks == 2'h0) |-> !channel_pin_owned_out[0])
        else $error("pin kept while released");
    chk_center_drive: assert property (
        run && mon_reg.center && mon_reg.ch0[1:0] != 2'h0 |-> channel_pin_oe_out[0])
        else $error("center mode pin 0 not driven");
    chk_center_all: assert property (
        run && mon_reg.center && mon_reg.els1 != 2'h0 |-> channel_pin_oe_out[1])
        else $error("center mode pin 1 not driven");
    chk_capture_input: assert property (
        cap0 |-> channel_pin_owned_out[0] && !channel_pin_oe_out[0])
        else $error("capture pin not a timer input");
    chk_compare_drive: assert property (
        drv0 && mon_reg.ch0[3:2] == 2'h1 |-> channel_pin_oe_out[0])
        else $error("compare pin not driven");
    chk_pwm_drive: assert property (
        drv0 && mon_reg.ch0[3] |-> channel_pin_oe_out[0] && channel_pin_owned_out[0])
        else $error("pwm pin not driven");
    chk_capture_sync: assert property (
        cap0 && $rose(channel_pin_in[0]) ##1 channel_pin_in[0] [*3] |-> ##[0:2] channel_pin_out[0])
        else $error("capture level not followed");
    chk_drive_owned: assert property (
        (channel_pin_oe_out & ~channel_pin_owned_out) == '0)
        else $error("pin driven while not owned");
    cover property (run && mon_reg.center && channel_pin_oe_out[1]);
    cover property (cap0 && $rose(channel_pin_in[0]));
    cover property (drv0 && mon_reg.ch0[3:2] == 2'h1 && $changed(channel_pin_out[0]));
endmodule
bind tpcpc_top tpcpc_top_monitor #(.NUM_CH(NUM_CH)) tpcpc_top_monitor_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
    .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
    .channel_pin_oe_out(channel_pin_oe_out), .channel_pin_owned_out(channel_pin_owned_out));
`default_nettype wire

// [tpcpc_pin_model.sv]
// Purpose: pins and port logic around the timer channels
// Assumes: port logic drives a pin whenever the timer output enable for it is low
// Notes: external clock pulses are made on request
`timescale 1ns/1ps
`default_nettype none
module tpcpc_pin_model #(
    parameter int NUM_CH = 2
) (
    // clock
    input wire logic clk_in,
    // timer side and port level
    input wire logic [NUM_CH-1:0] drive_in,
    input wire logic [NUM_CH-1:0] oe_in,
    input wire logic [NUM_CH-1:0] port_level_in,
    // pin levels and external clock
    output logic [NUM_CH-1:0] pin_level_out,
    output logic ext_clock_out
);
    assign pin_level_out = (oe_in & drive_in) | (~oe_in & port_level_in);
    initial ext_clock_out = 1'b0;
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge clk_in);
            ext_clock_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            ext_clock_out <= 1'b0;
            repeat (3) @(posedge clk_in);
        end
        repeat (6) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// [timer_channel_pin_control_bench.sv]
// Purpose: self-checking bench for the timer channel pin control block
// Assumes: zero-wait apb slave, external clock stepped by the pin model
// Notes: reads note their expected word in a queue; a watcher compares
`timescale 1ns/1ps
`default_nettype none
module timer_channel_pin_control_bench;
    import tpcpc_pkg::*;
    localparam logic [7:0] CH0C = TPCPC_OFF_CH0_CTL;
    localparam logic [7:0] CH1C = TPCPC_OFF_CH0_CTL + TPCPC_CH_STRIDE;
    logic clk_in, rst_n_in, psel, penable, pwrite, pready, ext_clock;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] pin_in, pin_out, pin_oe, pin_owned, port_level;
    logic [63:0] notes[$];
    int bad_count = 0;
    int samples_checked = 0;
    int hi0, hi1, k;
    tpcpc_top #(.NUM_CH(2)) tpcpc_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(),
        .ext_clock_in(ext_clock), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
        .channel_pin_oe_out(pin_oe), .channel_pin_owned_out(pin_owned));
    tpcpc_pin_model #(.NUM_CH(2)) tpcpc_pin_model_inst (.clk_in(clk_in), .drive_in(pin_out),
        .oe_in(pin_oe), .port_level_in(port_level), .pin_level_out(pin_in),
        .ext_clock_out(ext_clock));
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] e, input logic [31:0] m);
        int n;
        n = 0;
        @(posedge clk_in);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_in);
        penable <= 1'b1;
        if (!w) notes.push_back({m, e});
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) check("pready wait", 32'h0, 32'h1);
        if (n >= 20) close_out();
        {psel, penable} <= 2'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0, e, m);
    endtask
    task automatic count_high(input int skip, input int n);
        repeat (skip) @(posedge clk_in);
        {hi0, hi1} = '0;
        repeat (n) begin
            @(posedge clk_in);
            hi0 += pin_out[0];
            hi1 += pin_out[1];
        end
    endtask
    // oldest note is compared whenever a read completes
    always @(posedge clk_in) begin
        if (psel && penable && !pwrite && pready === 1'b1 && notes.size() > 0) begin
            check("read data", prdata & notes[0][63:32], notes[0][31:0]);
            void'(notes.pop_front());
        end
    end
    initial begin
        {rst_n_in, psel, penable, pwrite, paddr, pwdata, port_level} = '0;
        void'($urandom(32'hDD6D808D));
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        check("owned after reset", {30'h0, pin_owned}, 32'h0);
        rd(TPCPC_OFF_CTRL, {16'h0, TPCPC_FIX_DIV_RESET, 8'h00}, 32'h0000FFFF);
        rd(8'h40, 32'h0, 32'hFFFFFFFF);
        wr(TPCPC_OFF_CTRL, 32'h3);
        for (int code = 1; code < 4; code++) begin
            wr(CH0C, 32'h80 | code);
            wr(TPCPC_OFF_CNT, 32'h0);
            k = $urandom_range(6, 1);
            tpcpc_pin_model_inst.ext_pulses(k);
            check("capture owned", {30'h0, pin_owned & ~pin_oe}, 32'h1);
            port_level <= 2'h1;
            repeat (6) @(posedge clk_in);
            rd(CH0C, {24'h0, code[0], 7'h0}, 32'h80);
            if (code[0]) rd(TPCPC_OFF_CH0_VAL, k, 32'hFFFF);
            wr(CH0C, 32'h80 | code);
            port_level <= 2'h0;
            repeat (6) @(posedge clk_in);
            rd(CH0C, {24'h0, code[1], 7'h0}, 32'h80);
        end
        k = $urandom_range(5, 2);
        wr(TPCPC_OFF_CH0_VAL, k);
        wr(CH0C, 32'h87);
        for (int cs = 0; cs < 4; cs++) begin
            wr(TPCPC_OFF_CTRL, cs);
            repeat (3) @(posedge clk_in);
            check("clock source owned", {31'h0, pin_owned[0]}, cs != 0);
        end
        for (int code = 3; code > 0; code--) begin
            wr(TPCPC_OFF_CNT, 32'h0);
            wr(CH0C, 32'h84 | code);
            if (code == 1) rd(CH0C, 32'h0, 32'h100);
            @(negedge clk_in);
            check("compare oe", {31'h0, pin_oe[0]}, 32'h1);
            tpcpc_pin_model_inst.ext_pulses(k);
            rd(CH0C, {23'h0, code != 2, 8'h0}, 32'h100);
        end
        wr(TPCPC_OFF_CNT, 32'h0);
        wr(CH0C, 32'h84);
        tpcpc_pin_model_inst.ext_pulses(k);
        check("software timer owned", {31'h0, pin_owned[0]}, 32'h0);
        rd(CH0C, 32'h80, 32'h80);
        wr(TPCPC_OFF_MOD, 32'h8);
        wr(TPCPC_OFF_CH0_VAL, 32'h5);
        wr(TPCPC_OFF_CTRL, 32'h1);
        wr(CH0C, 32'h8A);
        count_high(20, 18);
        check("edge pwm high-true", hi0, 32'd10);
        wr(CH0C, 32'h89);
        count_high(20, 18);
        check("edge pwm low-true", hi0, 32'd8);
        wr(TPCPC_OFF_CH0_VAL + TPCPC_CH_STRIDE, 32'h5);
        wr(CH1C, 32'h81);
        wr(CH0C, 32'h82);
        wr(TPCPC_OFF_CTRL, 32'h5);
        count_high(40, 32);
        check("center oe", {30'h0, pin_oe}, 32'h3);
        check("center high-true", hi0, 32'd20);
        check("center low-true", hi1, 32'd12);
        close_out();
    end
endmodule
`default_nettype wire
